/* File: vadc_cfg_map.svh */
// Register map, field positions and reset values of the output and
// filter configuration group. Definitions only.
`ifndef VADC_CFG_MAP_SVH
`define VADC_CFG_MAP_SVH
`define OUT_EN_CTRL_ADDR 8'h06
`define OSCILLATOR_DIVIDER_ADDR 8'h07
`define LOOP_FILT_ADDR 8'h08
`define RSVD_NINE_ADDR 8'h09
`define PIXCLK_OE_BIT 6
`define CONV_CLK_OE_BIT 5
`define SYNC_OE_BIT 4
`define MARKER_SRC_BIT 3
`define MARKER_DLY_BIT 2
`define OUT_EN_WMASK 8'h7C
`define OUT_EN_RESET 8'h00
`define OSCILLATOR_DIVIDER_RESET 8'h00
`define SHUNT_BIT 7
`define RES_SEL_HI 6
`define RES_SEL_LO 4
`define CAP_SEL_HI 3
`define CAP_SEL_LO 1
`define FILT_SEL_BIT 0
`define LOOP_FILT_RESET 8'hFF
`endif

/* File: vadc_cfg_pkg.sv */
// Types shared by the configuration group and its helpers.
// Assumes the map header is compiled alongside.
package vadc_cfg_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] cap_sel_t;
endpackage

/* File: ref_clock_divider.sv */
// Reference clock divider: crystal clock halved, then divided by n.
// Assumes the crystal level is already synchronised to clk_in.
`timescale 1ns/1ps
`include "vadc_cfg_map.svh"
module ref_clock_divider #(
  parameter int DIV_W = 8
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic osc_rise_in,
  input wire logic [DIV_W-1:0] div_in,
  output logic ref_out
);
  localparam logic [DIV_W-1:0] CNT_ONE = DIV_W'(1);

  logic [DIV_W-1:0] cnt_ff;
  logic ref_ff;

  // Refuse widths the counter cannot hold
  if (DIV_W < 1) begin : g_bad_width
    $error("DIV_W must be positive");
  end

  // Each crystal rise is one half period of the halved clock, so a
  // toggle every n rises divides the halved clock by n, odd n too.
  // Zero is held as a stop rather than wrapping to a huge ratio.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_ff <= '0;
      ref_ff <= 1'b0;
    end else if (ce_in && osc_rise_in && div_in != '0) begin
      if (cnt_ff + CNT_ONE >= div_in) begin
        cnt_ff <= '0;
        ref_ff <= ~ref_ff;
      end else begin
        cnt_ff <= cnt_ff + CNT_ONE;
      end
    end
  end

  assign ref_out = ref_ff;
endmodule

/* File: line_marker_retime.sv */
// Line-marker retimer: chooses a source, synchronises it, and adds
// an optional extra clk_in cycle. clk_in is the block clock, not pix_clk_in.
`timescale 1ns/1ps
module line_marker_retime (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic src_sel_in,
  input wire logic dly_sel_in,
  input wire logic recov_hsync_in,
  input wire logic cond_hsync_in,
  output logic marker_out
);
  logic sync1_ff;
  logic sync2_ff;
  logic dly_ff;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      dly_ff <= 1'b0;
    end else if (ce_in) begin
      sync1_ff <= src_sel_in ? cond_hsync_in : recov_hsync_in;
      sync2_ff <= sync1_ff;
      dly_ff <= sync2_ff;
    end
  end

  assign marker_out = dly_sel_in ? dly_ff : sync2_ff;
endmodule

/* File: video_adc_output_and_filter_cfg.sv */
// What this block does
// - Pixel clock pin driven only when enabled
// - Conv clock disabled: tri-state, external clock used
// - Conv clock enabled: drive pin, internal clock
// - Sync disabled: tri-state, external sync used
// - Sync enabled: drive pin, internal sync
// - Source bit picks recovered or conditioned hsync
// - Line marker retimed into clk_in, not pix_clk_in
// - Delay bit adds one clk_in cycle
// - Crystal halved then divided by n
// - Shunt bit: 1 default, 0 alternate
// - Capacitor field selects (n+1) units, resets seven
// - Filter bit: 0 external, 1 internal
//
// Configuration registers reached through a byte register port fed by
// the serial-bus front end; assumes writes arrive as one-cycle strobes.
`timescale 1ns/1ps
`include "vadc_cfg_map.svh"
module video_adc_output_and_filter_cfg
  import vadc_cfg_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire vadc_cfg_pkg::byte_t reg_wdata_in,
  output vadc_cfg_pkg::byte_t reg_rdata_out,
  input wire logic pix_clk_in,
  input wire logic int_sync_in,
  input wire logic recov_hsync_in,
  input wire logic cond_hsync_in,
  input wire logic osc_in,
  input wire logic conv_clock_pin_in,
  input wire logic recovered_sync_pin_in,
  output logic pixclk_pin_out,
  output logic pixclk_pin_oe_out,
  output logic conv_clock_pin_out,
  output logic conv_clock_pin_oe_out,
  output logic recovered_sync_pin_out,
  output logic recovered_sync_pin_oe_out,
  output logic conv_clk_sel_out,
  output logic conv_sync_sel_out,
  output logic conv_sync_out,
  output logic line_marker_out,
  output logic ab_swap_out,
  output logic ref_clk_out,
  output logic shunt_default_out,
  output logic [2:0] res_sel_out,
  output vadc_cfg_pkg::cap_sel_t cap_sel_out,
  output logic filt_internal_out
);
  import vadc_cfg_pkg::*;

  byte_t out_en_ff;
  byte_t oscillator_divider_ff;
  byte_t loop_filt_ff;
  byte_t rdata_ff;
  logic osc_s1_ff;
  logic osc_s2_ff;
  logic osc_s3_ff;
  logic ext_clk_s1_ff;
  logic ext_clk_s2_ff;
  logic ext_sync_s1_ff;
  logic ext_sync_s2_ff;
  logic pixclk_ff;
  logic conv_clk_ff;
  logic rsync_ff;
  logic sync_mux_ff;
  logic marker_ff;
  logic ref_ff;
  logic marker_w;
  logic ref_w;
  logic conv_en_w;
  logic sync_en_w;

  // The register is a byte; other divider widths cannot be served
  if (DIV_W != 8) begin : g_bad_width
    $error("DIV_W must match the 8-bit register");
  end

  assign conv_en_w = out_en_ff[`CONV_CLK_OE_BIT];
  assign sync_en_w = out_en_ff[`SYNC_OE_BIT];

  // Output enable register; reserved bits masked so they stay zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      out_en_ff <= `OUT_EN_RESET;
    end else if (ce_in && reg_wr_in &&
                 reg_addr_in == `OUT_EN_CTRL_ADDR) begin
      out_en_ff <= reg_wdata_in & `OUT_EN_WMASK;
    end
  end

  // Oscillator divider; zero is held but stops the divider
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      oscillator_divider_ff <= `OSCILLATOR_DIVIDER_RESET;
    end else if (ce_in && reg_wr_in &&
                 reg_addr_in == `OSCILLATOR_DIVIDER_ADDR) begin
      oscillator_divider_ff <= reg_wdata_in;
    end
  end

  // Loop filter selections
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      loop_filt_ff <= `LOOP_FILT_RESET;
    end else if (ce_in && reg_wr_in && reg_addr_in == `LOOP_FILT_ADDR) begin
      loop_filt_ff <= reg_wdata_in;
    end
  end

  // Read mux; register nine and unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_ff <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      unique case (reg_addr_in)
        `OUT_EN_CTRL_ADDR: rdata_ff <= out_en_ff;
        `OSCILLATOR_DIVIDER_ADDR: rdata_ff <= oscillator_divider_ff;
        `LOOP_FILT_ADDR: rdata_ff <= loop_filt_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // Pin inputs from outside the domain pass two flops
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
      ext_clk_s1_ff <= 1'b0;
      ext_clk_s2_ff <= 1'b0;
      ext_sync_s1_ff <= 1'b0;
      ext_sync_s2_ff <= 1'b0;
    end else if (ce_in) begin
      osc_s1_ff <= osc_in;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
      ext_clk_s1_ff <= conv_clock_pin_in;
      ext_clk_s2_ff <= ext_clk_s1_ff;
      ext_sync_s1_ff <= recovered_sync_pin_in;
      ext_sync_s2_ff <= ext_sync_s1_ff;
    end
  end

  ref_clock_divider #(
    .DIV_W(DIV_W)
  ) u_ref_div (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .osc_rise_in(osc_s2_ff & ~osc_s3_ff),
    .div_in(oscillator_divider_ff),
    .ref_out(ref_w)
  );

  line_marker_retime u_marker (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .src_sel_in(out_en_ff[`MARKER_SRC_BIT]),
    .dly_sel_in(out_en_ff[`MARKER_DLY_BIT]),
    .recov_hsync_in(recov_hsync_in),
    .cond_hsync_in(cond_hsync_in),
    .marker_out(marker_w)
  );

  // Pin drive and input muxes, registered so outputs come from flops.
  // Pin data costs one cycle of latency; acceptable for a config block.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pixclk_ff <= 1'b0;
      conv_clk_ff <= 1'b0;
      rsync_ff <= 1'b0;
      sync_mux_ff <= 1'b0;
      marker_ff <= 1'b0;
      ref_ff <= 1'b0;
    end else if (ce_in) begin
      pixclk_ff <= pix_clk_in;
      conv_clk_ff <= conv_en_w ? pix_clk_in : ext_clk_s2_ff;
      rsync_ff <= int_sync_in;
      sync_mux_ff <= sync_en_w ? int_sync_in : ext_sync_s2_ff;
      marker_ff <= marker_w;
      ref_ff <= ref_w;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign pixclk_pin_out = pixclk_ff;
  assign pixclk_pin_oe_out = out_en_ff[`PIXCLK_OE_BIT];
  assign conv_clock_pin_out = conv_clk_ff;
  assign conv_clock_pin_oe_out = out_en_ff[`CONV_CLK_OE_BIT];
  assign recovered_sync_pin_out = rsync_ff;
  assign recovered_sync_pin_oe_out = out_en_ff[`SYNC_OE_BIT];
  assign conv_clk_sel_out = out_en_ff[`CONV_CLK_OE_BIT];
  assign conv_sync_sel_out = out_en_ff[`SYNC_OE_BIT];
  assign conv_sync_out = sync_mux_ff;
  assign line_marker_out = marker_ff;
  assign ab_swap_out = out_en_ff[`MARKER_DLY_BIT];
  assign ref_clk_out = ref_ff;
  assign shunt_default_out = loop_filt_ff[`SHUNT_BIT];
  assign res_sel_out = loop_filt_ff[`RES_SEL_HI:`RES_SEL_LO];
  assign cap_sel_out = loop_filt_ff[`CAP_SEL_HI:`CAP_SEL_LO];
  assign filt_internal_out = loop_filt_ff[`FILT_SEL_BIT];
endmodule

/* File: host_bus_model.sv */
// Host side of the register port: single-byte writes and reads.
// Assumes the block samples strobes on the rising clk_in edge.
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // Raw skips the host's own care, to probe the block's masking
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
    logic [7:0] v;
    v = (!raw && a == 8'h06) ? (d & 8'h7C) : d;
    if (!raw && a == 8'h07 && v == 8'h00) v = 8'h01;
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= v;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a; // Released lines do not keep the old value
    wdata_out <= ~v;
  endtask
  // Read data lands at the edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask
endmodule

/* File: video_adc_cfg_chk.sv */
// Port checker for the output and filter configuration group.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
`include "vadc_cfg_map.svh"
module video_adc_cfg_chk
  import vadc_cfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire vadc_cfg_pkg::byte_t reg_wdata_in,
  input wire logic pixclk_pin_oe_out,
  input wire logic conv_clock_pin_oe_out,
  input wire logic recovered_sync_pin_oe_out,
  input wire logic conv_clk_sel_out,
  input wire logic conv_sync_sel_out,
  input wire logic ab_swap_out,
  input wire logic shunt_default_out,
  input wire vadc_cfg_pkg::cap_sel_t cap_sel_out,
  input wire logic filt_internal_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Accepted writes to the enable and filter registers
  sequence s_wr06;
    ce_in && reg_wr_in && reg_addr_in == `OUT_EN_CTRL_ADDR;
  endsequence
  sequence s_wr08;
    ce_in && reg_wr_in && reg_addr_in == `LOOP_FILT_ADDR;
  endsequence
  a_oe_write: assert property (
    s_wr06 |=> {pixclk_pin_oe_out, conv_clock_pin_oe_out,
    recovered_sync_pin_oe_out} == $past(reg_wdata_in[6:4]))
    else $error("enable outputs differ from write");
  a_oe_hold: assert property (
    !(ce_in && reg_wr_in && reg_addr_in == `OUT_EN_CTRL_ADDR)
    |=> $stable(pixclk_pin_oe_out))
    else $error("pixel clock enable moved without write");
  a_conv_clk_tie: assert property (
    conv_clk_sel_out == conv_clock_pin_oe_out)
    else $error("clock select and clock enable differ");
  a_sync_sel_tie: assert property (
    conv_sync_sel_out == recovered_sync_pin_oe_out)
    else $error("sync select and sync enable differ");
  a_clk_sel_write: assert property (
    s_wr06 |=> conv_clk_sel_out == $past(reg_wdata_in[`CONV_CLK_OE_BIT]))
    else $error("clock select differs from write");
  a_sync_sel_write: assert property (
    s_wr06 |=> conv_sync_sel_out == $past(reg_wdata_in[`SYNC_OE_BIT]))
    else $error("sync select differs from write");
  a_swap_write: assert property (
    s_wr06 |=> ab_swap_out == $past(reg_wdata_in[2]))
    else $error("swap output differs from write");
  a_cap_write: assert property (
    s_wr08 |=> cap_sel_out == $past(reg_wdata_in[3:1]))
    else $error("capacitor select differs from write");
  a_filt_write: assert property (
    s_wr08 |=> {shunt_default_out, filt_internal_out}
    == {$past(reg_wdata_in[7]), $past(reg_wdata_in[0])})
    else $error("filter bits differ from write");
  a_oe_reset: assert property (
    $fell(srst_in) |-> !pixclk_pin_oe_out && !conv_clock_pin_oe_out
    && !recovered_sync_pin_oe_out)
    else $error("enables not cleared by reset");
endmodule
bind video_adc_output_and_filter_cfg video_adc_cfg_chk i_chk (.*);

/* File: video_adc_output_and_filter_cfg_tb_top.sv */
// Self-checking bench for the output and filter configuration group.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module video_adc_output_and_filter_cfg_tb_top;
  import vadc_cfg_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic osc_in = 1'b0;
  logic recov_hsync_in = 1'b0;
  logic cond_hsync_in = 1'b0;
  logic pix_clk_in = 1'b0;
  logic int_sync_in = 1'b0;
  logic conv_clock_pin_in = 1'b0;
  logic recovered_sync_pin_in = 1'b0;
  logic reg_wr_in, reg_rd_in, prev;
  logic [7:0] reg_addr_in;
  byte_t reg_wdata_in, reg_rdata_out, rd;
  logic pixclk_pin_out, pixclk_pin_oe_out, conv_clock_pin_out;
  logic conv_clock_pin_oe_out, recovered_sync_pin_out;
  logic recovered_sync_pin_oe_out, conv_clk_sel_out, conv_sync_sel_out;
  logic conv_sync_out, line_marker_out, ab_swap_out, ref_clk_out;
  logic shunt_default_out, filt_internal_out;
  logic [2:0] res_sel_out;
  cap_sel_t cap_sel_out;
  int failures = 0;
  int compares = 0;
  int n;
  // Rows: address, written byte, expected readback
  logic [23:0] rows [7] = '{24'h06FF7C, 24'h067070, 24'h075A5A,
    24'h080000, 24'h08FFFF, 24'h09AA00, 24'h205500};
  logic [15:0] rst_rows [3] = '{16'h0600, 16'h0700, 16'h08FF};
  // Pin rows: enables, {pix, int sync, ext clock, ext sync}, outputs
  logic [23:0] pin_rows [5] = '{24'h70C1FF, 24'h00C110, 24'h003041,
    24'h4060D0, 24'h30302E};
  logic [8:0] pins;
  logic [7:0] filt;
  // Pin and mux outputs, and the filter fields in register order
  assign pins = {pixclk_pin_out, pixclk_pin_oe_out, conv_clock_pin_out,
    conv_clock_pin_oe_out, recovered_sync_pin_out,
    recovered_sync_pin_oe_out, conv_clk_sel_out, conv_sync_sel_out,
    conv_sync_out};
  assign filt = {shunt_default_out, res_sel_out, cap_sel_out,
    filt_internal_out};
  always #5 clk_in = ~clk_in;
  video_adc_output_and_filter_cfg i_dut (.*);
  host_bus_model i_host (.clk_in(clk_in), .rdata_in(reg_rdata_out),
    .wr_out(reg_wr_in), .rd_out(reg_rd_in), .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check_pins(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pulse one source; a wrong source must time out at 20
  task automatic marker(input bit src, input bit dly, input bit which);
    i_host.wr(8'h06, {4'h0, src, dly, 2'b00}, 1'b0);
    repeat (6) @(posedge clk_in);
    if (which) cond_hsync_in <= 1'b1;
    else recov_hsync_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      cond_hsync_in <= 1'b0;
      recov_hsync_in <= 1'b0;
      #1;
      n++;
    end while (line_marker_out !== 1'b1 && n < 20);
    check(8'(n), (which == src) ? 8'(3 + dly) : 8'd20);
    check({7'h0, ab_swap_out}, {7'h0, dly});
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      i_host.wr(rows[i][23:16], rows[i][15:8], 1'b1);
      i_host.rd(rows[i][23:16], rd);
      check(rd, rows[i][7:0]);
    end
    for (int i = 0; i < 8; i++)
      marker(i[0], i[1], i[2]);
    // Pins settle within three edges of the slowest (synced) input
    for (int i = 0; i < 5; i++) begin
      i_host.wr(8'h06, pin_rows[i][23:16], 1'b0);
      {pix_clk_in, int_sync_in, conv_clock_pin_in, recovered_sync_pin_in}
        <= pin_rows[i][15:12];
      repeat (4) @(posedge clk_in);
      #1;
      check_pins(pins, pin_rows[i][8:0]);
    end
    // Crystal at half clock rate, divider two: osc/4, so ref toggles
    // every four clocks; 80 in the window less the sync latency
    i_host.wr(8'h07, 8'h02, 1'b0);
    n = 0;
    #1;
    prev = ref_clk_out;
    repeat (320) begin
      @(posedge clk_in);
      osc_in <= ~osc_in;
      #1;
      if (ref_clk_out !== prev) n++;
      prev = ref_clk_out;
    end
    check({7'h0, n inside {[78:80]}}, 8'h01);
    // Distinct filter pattern so the reset check below can trip
    i_host.wr(8'h08, 8'h5A, 1'b0);
    #1;
    check(filt, 8'h5A);
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      i_host.rd(rst_rows[i][15:8], rd);
      check(rd, rst_rows[i][7:0]);
    end
    check(filt, 8'hFF);
    check_pins(pins, 9'h041);
    test_done();
  end
endmodule
